// ==== verilog/pwmtb_pkg.sv ====
// constants of the pwm timebase: register indices, field layout, reset values, codes
// assumes a byte-addressed avalon slave where byte address = 4 * register index
// Behaviour
// RL1 - a 4-bit field picks the count clock: 0000/0001 routed pins, 0010 system clock, 0011-0111 internal or secondary oscillators, 1000 external oscillator, 1001-1110 peripheral outputs, 1111 reserved.
// RL2 - in sleep the timer counts only while its selected clock runs, and the system clock source stops in sleep.
// RL3 - a 3-bit field picks the auto-load trigger: 000 off, 001/010 routed pins, 011-110 logic cell outputs, 111 reserved.
// RL4 - a 16-bit period value sets the period length in prescaled clock periods.
// RL5 - the high and low bytes of the period are two separate byte registers.
// RL6 - the selected clock is divided by the prescale value plus one before the timer.
// RL7 - one period interrupt is raised per postscale value plus one period events.
// RL8 - a period event happens when the timer equals the period and restarts the timer.
// RL9 - clearing enable clears the postscale counter, and postscale changes act at once.
// RL10 - while running, a new period is copied to the working buffer only at a period end, after a software reload or a trigger event.
// RL11 - clock source and trigger are synchronised before use so a switch cannot make runt pulses.
package pwmtb_pkg;
  // register indices
  localparam logic [11:0] IDX_CLK_SEL   = 12'h48D;
  localparam logic [11:0] IDX_TRIG_SEL  = 12'h48E;
  localparam logic [11:0] IDX_PER_LOW   = 12'h48F;
  localparam logic [11:0] IDX_PER_HIGH  = 12'h490;
  localparam logic [11:0] IDX_PRESCALE  = 12'h491;
  localparam logic [11:0] IDX_POSTSCALE = 12'h492;
  localparam logic [11:0] IDX_CONTROL   = 12'h495;
  localparam logic [11:0] IDX_STATUS    = 12'h496;
  localparam logic [11:0] IDX_MASK      = 12'h497;
  // field layout
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_RELOAD_BIT = 2;
  localparam int STAT_PERIOD_IRQ = 0;
  localparam int STAT_LOAD_DONE  = 1;
  localparam int STAT_W          = 2;
  localparam int CLK_SRC_N       = 16;
  localparam int TRIG_SRC_N      = 6;
  // source codes
  localparam logic [3:0] CLK_SYSTEM   = 4'h2;
  localparam logic [3:0] CLK_RESERVED = 4'hF;
  localparam logic [2:0] TRIG_OFF      = 3'h0;
  localparam logic [2:0] TRIG_RESERVED = 3'h7;
  // reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_PERIOD = 16'h0000;
endpackage

// ==== verilog/pwmtb_sync_if.sv ====
// carries raw asynchronous source levels into the synchroniser and the settled copies out
// assumes the synchroniser and its user share one clock
`timescale 1ns/1ps
`default_nettype none
interface pwmtb_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] settled;
  modport sync (input raw, output settled);
  modport user (output raw, input settled);
endinterface
`default_nettype wire

// ==== verilog/pwmtb_sync.sv ====
// two-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level relative to the clock
`timescale 1ns/1ps
`default_nettype none
module pwmtb_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic  clock,
  input  wire logic  rstn,
  // levels
  pwmtb_sync_if.sync port
);
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } pwmtb_sync_t;

  pwmtb_sync_t st;
  pwmtb_sync_t next_st;

  always_comb
  begin
    next_st        = st;
    next_st.first  = port.raw;
    next_st.second = st.first;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

  assign port.settled = st.second;
endmodule
`default_nettype wire

// ==== verilog/pwmtb_timebase.sv ====
// pwm timebase: clock source select, prescaler, period timer, reload buffer, postscaled irq
// assumes avalon-mm master on clock; source and trigger inputs are asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module pwmtb_timebase #(
  parameter int TIMER_W = 16
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // avalon-mm slave
  input  wire logic [15:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output var  logic [31:0] readdata,
  output var  logic        waitrequest,
  // clock sources, index = select code; bits for system clock and reserved are unused
  input  wire logic [15:0] clock_sources,
  // trigger sources: routed_input_zero, routed_input_one, logic cells one to four
  input  wire logic [5:0]  trigger_sources,
  // power state from the system controller
  input  wire logic        sleep,
  // results
  output var  logic [15:0] timer_value,
  output var  logic        period_event,
  output var  logic        irq
);
  generate
    if (TIMER_W != 16)
    begin : g_bad_width
      $error("pwmtb_timebase: TIMER_W must be 16");
    end
  endgenerate

  typedef struct packed {
    logic [3:0]  clk_sel;
    logic [2:0]  trig_sel;
    logic [15:0] period_count;
    logic [7:0]  prescale_value;
    logic [7:0]  period_irq_ratio;
    logic        enable;
    logic        reload_request;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [15:0] period_buf;
    logic [15:0] timer;
    logic [7:0]  pre_cnt;
    logic [7:0]  post_cnt;
    logic [15:0] clk_prev;
    logic [5:0]  trig_prev;
    logic        load_pend;
    logic        waitrequest;
    logic [31:0] readdata;
    logic        irq;
    logic        period_event;
  } pwmtb_state_t;

  pwmtb_state_t st;
  pwmtb_state_t next_st;

  pwmtb_sync_if #(.W(pwmtb_pkg::CLK_SRC_N))  clk_if ();
  pwmtb_sync_if #(.W(pwmtb_pkg::TRIG_SRC_N)) trig_if ();

  assign clk_if.raw  = clock_sources;
  assign trig_if.raw = trigger_sources;

  pwmtb_sync #(.W(pwmtb_pkg::CLK_SRC_N)) u_clk_sync (
    .clock (clock),
    .rstn  (rstn),
    .port  (clk_if)
  );

  pwmtb_sync #(.W(pwmtb_pkg::TRIG_SRC_N)) u_trig_sync (
    .clock (clock),
    .rstn  (rstn),
    .port  (trig_if)
  );

  logic [11:0] reg_index;
  logic        word_ok;
  logic        accept;
  logic        clk_level;
  logic        clk_tick;
  logic        pre_tick;
  logic        trig_level;
  logic        trig_edge;
  logic        per_hit;
  logic        irq_hit;
  logic [1:0]  status_set;
  logic [31:0] read_mux;

  assign reg_index = address[13:2];
  assign word_ok   = (address[15:14] == 2'h0) && (address[1:0] == 2'h0);
  assign accept    = (read || write) && !st.waitrequest;

  always_comb
  begin
    clk_level = 1'b0;
    clk_tick  = 1'b0;
    // system clock runs every cycle but halts in sleep; reserved code never ticks
    if (st.clk_sel == pwmtb_pkg::CLK_SYSTEM) // RL1
    begin
      clk_tick = !sleep; // RL2
    end
    else if (st.clk_sel != pwmtb_pkg::CLK_RESERVED) // RL1
    begin
      // a source stopped in sleep simply makes no edges
      clk_level = clk_if.settled[st.clk_sel]; // RL11
      clk_tick  = clk_level && !st.clk_prev[st.clk_sel]; // RL2
    end
  end

  always_comb
  begin
    trig_level = 1'b0;
    trig_edge  = 1'b0;
    if (st.trig_sel != pwmtb_pkg::TRIG_OFF && st.trig_sel != pwmtb_pkg::TRIG_RESERVED) // RL3
    begin
      // edge against the same source's own last level, so a selection change is no event
      trig_level = trig_if.settled[3'(st.trig_sel - 3'h1)]; // RL11
      trig_edge  = trig_level && !st.trig_prev[3'(st.trig_sel - 3'h1)]; // RL10
    end
  end

  assign pre_tick  = st.enable && clk_tick && (st.pre_cnt == st.prescale_value); // RL6
  assign per_hit   = pre_tick && (st.timer == st.period_buf); // RL8
  assign irq_hit   = per_hit && (st.post_cnt == st.period_irq_ratio); // RL7

  always_comb
  begin
    read_mux = 32'h0000_0000;
    if (word_ok)
    begin
      unique case (reg_index)
        pwmtb_pkg::IDX_CLK_SEL:   read_mux = {28'h0, st.clk_sel};
        pwmtb_pkg::IDX_TRIG_SEL:  read_mux = {29'h0, st.trig_sel};
        pwmtb_pkg::IDX_PER_LOW:   read_mux = {24'h0, st.period_count[7:0]}; // RL5
        pwmtb_pkg::IDX_PER_HIGH:  read_mux = {24'h0, st.period_count[15:8]}; // RL5
        pwmtb_pkg::IDX_PRESCALE:  read_mux = {24'h0, st.prescale_value};
        pwmtb_pkg::IDX_POSTSCALE: read_mux = {24'h0, st.period_irq_ratio};
        pwmtb_pkg::IDX_CONTROL:   read_mux = {24'h0, st.enable, 4'h0, st.reload_request, 2'h0};
        pwmtb_pkg::IDX_STATUS:    read_mux = {30'h0, st.status};
        pwmtb_pkg::IDX_MASK:      read_mux = {30'h0, st.mask};
        default:                  read_mux = 32'h0000_0000;
      endcase
    end
  end

  always_comb
  begin
    next_st = st;
    status_set = 2'h0;
    // one wait cycle per access; waitrequest idles high
    next_st.waitrequest = !((read || write) && st.waitrequest);
    if ((read || write) && st.waitrequest)
    begin
      next_st.readdata = read ? read_mux : 32'h0000_0000;
    end
    if (write && accept && word_ok && byteenable[0])
    begin
      unique case (reg_index)
        pwmtb_pkg::IDX_CLK_SEL:   next_st.clk_sel = writedata[3:0]; // RL1
        pwmtb_pkg::IDX_TRIG_SEL:  next_st.trig_sel = writedata[2:0]; // RL3
        pwmtb_pkg::IDX_PER_LOW:   next_st.period_count[7:0] = writedata[7:0]; // RL5
        pwmtb_pkg::IDX_PER_HIGH:  next_st.period_count[15:8] = writedata[7:0]; // RL5
        pwmtb_pkg::IDX_PRESCALE:  next_st.prescale_value = writedata[7:0];
        pwmtb_pkg::IDX_POSTSCALE: next_st.period_irq_ratio = writedata[7:0]; // RL9
        pwmtb_pkg::IDX_CONTROL:
        begin
          next_st.enable = writedata[pwmtb_pkg::CTRL_ENABLE_BIT];
          next_st.reload_request = writedata[pwmtb_pkg::CTRL_RELOAD_BIT] | st.reload_request;
        end
        pwmtb_pkg::IDX_MASK:      next_st.mask = writedata[1:0];
        default:                  next_st.mask = st.mask;
      endcase
    end
    if (read && accept && word_ok && reg_index == pwmtb_pkg::IDX_STATUS)
    begin
      next_st.status = 2'h0;
    end

    // every source keeps its own last level, so switching sources cannot fake an edge
    next_st.clk_prev  = clk_if.settled; // RL11
    next_st.trig_prev = trig_if.settled;
    next_st.period_event = per_hit;

    if (!st.enable)
    begin
      // stopped: counters cleared, buffer follows the register so enabling starts fresh
      next_st.pre_cnt    = 8'h00;
      next_st.timer      = 16'h0000;
      next_st.post_cnt   = 8'h00; // RL9
      next_st.period_buf = st.period_count;
      next_st.load_pend  = 1'b0;
    end
    else
    begin
      if (trig_edge)
      begin
        next_st.load_pend = 1'b1; // RL10
      end
      if (clk_tick)
      begin
        next_st.pre_cnt = pre_tick ? 8'h00 : 8'(st.pre_cnt + 8'h01); // RL6
      end
      if (pre_tick)
      begin
        next_st.timer = per_hit ? 16'h0000 : 16'(st.timer + 16'h0001); // RL4
      end
      if (per_hit)
      begin
        next_st.post_cnt = irq_hit ? 8'h00 : 8'(st.post_cnt + 8'h01); // RL7
        if (st.reload_request || st.load_pend || trig_edge)
        begin
          next_st.period_buf     = st.period_count; // RL10
          next_st.reload_request = 1'b0;
          next_st.load_pend      = 1'b0;
          status_set[pwmtb_pkg::STAT_LOAD_DONE] = 1'b1;
        end
      end
      if (irq_hit)
      begin
        status_set[pwmtb_pkg::STAT_PERIOD_IRQ] = 1'b1; // RL7
      end
    end
    // a new event wins over a clearing read
    next_st.status = next_st.status | status_set;
    next_st.irq = |(next_st.status & st.mask);
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.waitrequest <= 1'b1;
      st.period_count <= pwmtb_pkg::RST_PERIOD;
      st.period_buf <= pwmtb_pkg::RST_PERIOD;
      st.prescale_value <= pwmtb_pkg::RST_BYTE;
      st.period_irq_ratio <= pwmtb_pkg::RST_BYTE;
    end
    else
      st <= next_st;
  end

  assign readdata     = st.readdata;
  assign waitrequest  = st.waitrequest;
  assign timer_value  = st.timer;
  assign period_event = st.period_event;
  assign irq          = st.irq;

  // helper: selected-clock ticks since the last prescaled tick
  logic [8:0] since_tick;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      since_tick <= 9'h000;
    else if (pre_tick || !st.enable)
      since_tick <= 9'h000;
    else if (clk_tick && since_tick != 9'h1FF)
      since_tick <= 9'(since_tick + 9'h001);
  end

  chk_sleep_stop: assert property (@(posedge clock) disable iff (!rstn) // RL2
    (st.enable && sleep && st.clk_sel == pwmtb_pkg::CLK_SYSTEM)
      |=> $stable(st.pre_cnt) && $stable(st.timer))
    else $error("system clock source counted during sleep");

  chk_reserved_clk: assert property (@(posedge clock) disable iff (!rstn) // RL1
    (st.clk_sel == pwmtb_pkg::CLK_RESERVED) |-> !clk_tick)
    else $error("reserved clock source produced a tick");

  chk_prescale_span: assert property (@(posedge clock) disable iff (!rstn) // RL6
    (st.enable && clk_tick && !pre_tick) |-> (since_tick[7:0] <= st.prescale_value))
    else $error("prescaler passed more ticks than its value");

  chk_period_wrap: assert property (@(posedge clock) disable iff (!rstn) // RL8
    per_hit |=> (st.timer == 16'h0000) && period_event)
    else $error("timer did not restart at period event");

  chk_timer_bound: assert property (@(posedge clock) disable iff (!rstn) // RL4
    st.enable |-> (st.timer <= st.period_buf))
    else $error("timer ran beyond the period");

  chk_post_clear: assert property (@(posedge clock) disable iff (!rstn) // RL9
    !st.enable |=> (st.post_cnt == 8'h00) && (st.timer == 16'h0000))
    else $error("counters not cleared while disabled");

  chk_irq_ratio: assert property (@(posedge clock) disable iff (!rstn) // RL7
    (per_hit && st.post_cnt != st.period_irq_ratio) |=> !st.status[pwmtb_pkg::STAT_PERIOD_IRQ] || $past(st.status[0]))
    else $error("period irq raised before postscale count");

  chk_buf_hold: assert property (@(posedge clock) disable iff (!rstn) // RL10
    (st.enable && !per_hit) |=> $stable(st.period_buf))
    else $error("working period changed outside a period end");

  chk_reload_take: assert property (@(posedge clock) disable iff (!rstn) // RL10
    (per_hit && st.reload_request) |=> (st.period_buf == $past(st.period_count)) && !st.reload_request)
    else $error("reload request not served at period end");

  chk_bus_answer: assert property (@(posedge clock) disable iff (!rstn) // RL5
    (read && st.waitrequest) |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not after one wait cycle");

  chk_irq_level: assert property (@(posedge clock) disable iff (!rstn) // RL7
    st.irq |-> ((st.status & $past(st.mask)) != 2'h0))
    else $error("irq high without an unmasked status bit");

  chk_trig_ignored: assert property (@(posedge clock) disable iff (!rstn) // RL3
    (st.trig_sel == pwmtb_pkg::TRIG_OFF || st.trig_sel == pwmtb_pkg::TRIG_RESERVED)
      |-> !trig_edge)
    else $error("disabled or reserved trigger produced an event");

  chk_trig_load: assert property (@(posedge clock) disable iff (!rstn) // RL10
    (per_hit && st.load_pend) |=> (st.period_buf == $past(st.period_count)) && !st.load_pend)
    else $error("pending trigger load not served at period end");

  chk_post_step: assert property (@(posedge clock) disable iff (!rstn) // RL7
    (per_hit && !irq_hit) |=> (st.post_cnt == 8'($past(st.post_cnt) + 8'h01)))
    else $error("postscale counter did not step on a period event");

  chk_irq_wrap: assert property (@(posedge clock) disable iff (!rstn) // RL7
    irq_hit |=> (st.post_cnt == 8'h00) && st.status[pwmtb_pkg::STAT_PERIOD_IRQ])
    else $error("postscale wrap did not raise the period irq");

  chk_event_pulse: assert property (@(posedge clock) disable iff (!rstn) // RL8
    !per_hit |=> !period_event)
    else $error("period event without a timer match");

  chk_idle_track: assert property (@(posedge clock) disable iff (!rstn) // RL10
    !st.enable |=> (st.period_buf == $past(st.period_count)))
    else $error("stopped buffer does not follow the period register");

  chk_load_flag: assert property (@(posedge clock) disable iff (!rstn) // RL10
    (per_hit && st.reload_request) |=> st.status[pwmtb_pkg::STAT_LOAD_DONE])
    else $error("load done flag not raised by a served reload");

  chk_write_answer: assert property (@(posedge clock) disable iff (!rstn) // RL5
    (write && st.waitrequest) |=> !waitrequest ##1 waitrequest)
    else $error("write answer not after one wait cycle");

  chk_wait_idle: assert property (@(posedge clock) disable iff (!rstn) // RL5
    !(read || write) |=> waitrequest)
    else $error("waitrequest low without a request");
endmodule
`default_nettype wire

// ==== bench/pwm_timebase_config_test.sv ====
// self-checking bench of the pwm timebase: registers, clock select, sleep, reload, irq
// assumes pwmtb_timebase with its package; bench drives every port itself
`timescale 1ns/1ps
`default_nettype none
module pwm_timebase_config_test;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] address = 16'h0000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [15:0] clock_sources = 16'h0000;
  logic [5:0]  trigger_sources = 6'h00;
  logic        sleep = 1'b0;
  logic [15:0] timer_value;
  logic        period_event;
  logic        irq;
  logic [31:0] r;
  logic [31:0] r2;
  logic [7:0]  v[6];
  logic [7:0]  fm[6] = '{8'h0F, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0]  rq_e[$];
  logic [7:0]  rq_m[$];
  int          gq[$];
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          seed = 64899;
  int          tsel = 0;
  int          gap = 0;
  int          cyc = 0;
  int          ev_n = 0;
  int          n0;
  int          per;

  always #2 clock = ~clock;

  pwmtb_timebase u_dut (
    .clock(clock), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .clock_sources(clock_sources),
    .trigger_sources(trigger_sources), .sleep(sleep), .timer_value(timer_value),
    .period_event(period_event), .irq(irq)
  );

  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_gap(input int got, input int exp);
    cmp_word(32'(got), 32'(exp));
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask

  // one avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [11:0] i, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge clock);
    address <= {2'b00, i, 2'b00};
    writedata <= {24'h0, d};
    byteenable <= be;
    read <= ~wr;
    write <= wr;
    do @(posedge clock); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    bus(1'b1, i, d, 4'hF);
  endtask

  task automatic rd(input logic [11:0] i, input logic [7:0] e, input logic [7:0] m);
    @(negedge clock);
    rq_e.push_back(e & m);
    rq_m.push_back(m);
    bus(1'b0, i, 8'h00, 4'hF);
  endtask

  task automatic wait_ev();
    do @(posedge clock); while (period_event !== 1'b1);
  endtask

  // note n expected gaps between period events, then let the monitor use them up
  task automatic chk_gaps(input int e, input int n);
    wait_ev();
    @(negedge clock);
    repeat (n) gq.push_back(e);
    while (gq.size() > 0) @(posedge clock);
  endtask

  // monitor: read data, gaps between events, timeout
  always @(posedge clock)
  begin
    cyc++;
    gap++;
    if (read && waitrequest === 1'b0)
      cmp_word(readdata & {24'h0, rq_m.pop_front()}, {24'h0, rq_e.pop_front()});
    if (period_event === 1'b1)
    begin
      ev_n++;
      cmp_word({16'h0, timer_value}, 32'h0000_0000);
      if (gq.size() > 0)
        cmp_gap(gap, gq.pop_front());
      gap = 0;
    end
    if (cyc > 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // random levels on every source, the selected one toggles with a period of 8 cycles
  always @(posedge clock)
  begin
    r2 = $random(seed);
    r2[tsel] = cyc[2];
    clock_sources <= r2[15:0];
  end

  initial
  begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 11; i++)
      rd(12'h48D + 12'(i), 8'h00, 8'hFF);
    for (int i = 0; i < 6; i++)
    begin
      r = $random(seed);
      v[i] = r[7:0] & fm[i];
      wr(12'h48D + 12'(i), r[7:0]);
    end
    for (int i = 0; i < 6; i++)
      rd(12'h48D + 12'(i), v[i], fm[i]);
    bus(1'b1, pwmtb_pkg::IDX_PER_HIGH, ~v[3], 4'hE);
    rd(pwmtb_pkg::IDX_PER_HIGH, v[3], 8'hFF);
    wr(12'h493, 8'hA5);
    rd(12'h493, 8'h00, 8'hFF);
    wr(pwmtb_pkg::IDX_PRESCALE, 8'h01);
    wr(pwmtb_pkg::IDX_PER_HIGH, 8'h00);
    wr(pwmtb_pkg::IDX_PER_LOW, 8'h01);
    wr(pwmtb_pkg::IDX_POSTSCALE, 8'h00);
    wr(pwmtb_pkg::IDX_TRIG_SEL, 8'h00);
    wr(pwmtb_pkg::IDX_CONTROL, 8'h80);
    // every clock code: prescale 2, period 2
    for (int c = 0; c < 16; c++)
    begin
      tsel = c;
      wr(pwmtb_pkg::IDX_CLK_SEL, 8'(c));
      if (c == 15)
      begin
        repeat (20) @(posedge clock);
        n0 = ev_n;
        repeat (80) @(posedge clock);
        cmp_gap(ev_n - n0, 0);
      end
      else
      begin
        // skip the event that may still belong to the previous source
        wait_ev();
        chk_gaps(c == 2 ? 4 : 32, 2);
      end
    end
    wr(pwmtb_pkg::IDX_CONTROL, 8'h00);
    wr(pwmtb_pkg::IDX_CLK_SEL, 8'h02);
    wr(pwmtb_pkg::IDX_PRESCALE, 8'h00);
    wr(pwmtb_pkg::IDX_PER_LOW, 8'h02);
    wr(pwmtb_pkg::IDX_CONTROL, 8'h80);
    chk_gaps(3, 2);
    wait_ev();
    sleep <= 1'b1;
    @(negedge clock);
    gq.push_back(8);
    repeat (5) @(posedge clock);
    cmp_word({16'h0, timer_value}, 32'h0000_0001);
    sleep <= 1'b0;
    chk_gaps(3, 1);
    wr(pwmtb_pkg::IDX_PER_LOW, 8'h05);
    chk_gaps(3, 2);
    wr(pwmtb_pkg::IDX_CONTROL, 8'h84);
    wait_ev();
    chk_gaps(6, 2);
    rd(pwmtb_pkg::IDX_STATUS, 8'h02, 8'h02);
    rd(pwmtb_pkg::IDX_CONTROL, 8'h80, 8'h84);
    per = 5;
    for (int c = 0; c < 8; c++)
    begin
      wr(pwmtb_pkg::IDX_TRIG_SEL, 8'(c));
      wr(pwmtb_pkg::IDX_PER_LOW, 8'(c + 3));
      trigger_sources <= (c == 0 || c == 7) ? 6'h3F : 6'(1 << (c - 1));
      if (c > 0 && c < 7)
        per = c + 3;
      repeat (8) @(posedge clock);
      trigger_sources <= 6'h00;
      wait_ev();
      chk_gaps(per + 1, 2);
    end
    wr(pwmtb_pkg::IDX_CONTROL, 8'h00);
    wr(pwmtb_pkg::IDX_POSTSCALE, 8'h02);
    wr(pwmtb_pkg::IDX_MASK, 8'h01);
    rd(pwmtb_pkg::IDX_STATUS, 8'h00, 8'h00);
    wr(pwmtb_pkg::IDX_CONTROL, 8'h80);
    wait_ev();
    wait_ev();
    cmp_flag(irq, 1'b0);
    rd(pwmtb_pkg::IDX_STATUS, 8'h00, 8'h01);
    wait_ev();
    repeat (3) @(posedge clock);
    cmp_flag(irq, 1'b1);
    rd(pwmtb_pkg::IDX_STATUS, 8'h01, 8'h01);
    repeat (3) @(posedge clock);
    cmp_flag(irq, 1'b0);
    wr(pwmtb_pkg::IDX_MASK, 8'h00);
    repeat (3) wait_ev();
    repeat (3) @(posedge clock);
    cmp_flag(irq, 1'b0);
    rd(pwmtb_pkg::IDX_STATUS, 8'h01, 8'h01);
    report_and_stop();
  end
endmodule
`default_nettype wire
